// ### hdl/sfx_exec.sv
// subtract instruction execution datapath with apb register access
`timescale 1ns/1ps
`include "sfx_cfg.svh"

module sfx_exec
  import sfx_pkg::*;
(
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // data memory
  output logic [11:0]      mem_addr,
  output logic             mem_rd_en,
  input  wire logic [7:0]  mem_rdata,
  output logic             mem_wr_en,
  output logic [7:0]       mem_wdata,
  // status
  output logic             busy
);

  // ************************************************************
  // state
  // ************************************************************
  sfx_state_s st_q;
  sfx_state_s st_d;

  logic        busy_w;
  logic        setup_w;
  logic        acc_w;
  logic        wr_ok_w;
  logic [7:0]  minuend_w;
  logic [7:0]  diff_w;
  logic        borrow_w;
  logic        nib_borrow_w;
  logic [4:0]  calc_flags_w;
  logic [7:0]  fld_f_w;
  logic        fld_a_w;
  logic        fld_d_w;
  logic [11:0] eff_addr_w;
  logic [31:0] rd_mux_w;
  logic        mapped_w;
  logic [15:0] new_instr_w;
  logic [8:0]  brw_w;
  logic        is_lit_w;
  logic        is_reg_w;
  logic        in_q2_w;
  logic        in_q3_w;
  logic        in_q4_w;

  assign busy_w  = (st_q.phase != SFX_IDLE);

  // ************************************************************
  // apb handshake
  // ************************************************************
  assign setup_w = psel && !penable;
  assign acc_w   = psel && penable;
  // writes stall while an instruction is in flight
  assign wr_ok_w = acc_w && pwrite && !busy_w;

  // ************************************************************
  // phase decode
  // ************************************************************
  assign in_q2_w = (st_q.phase == SFX_Q2);
  assign in_q3_w = (st_q.phase == SFX_Q3);
  assign in_q4_w = (st_q.phase == SFX_Q4);

  // ************************************************************
  // decode fields
  // ************************************************************
  assign fld_f_w = st_q.instr[7:0];
  assign fld_a_w = st_q.instr[`SFX_A_BIT];
  assign fld_d_w = st_q.instr[`SFX_D_BIT];

  // ************************************************************
  // opcode match
  // ************************************************************
  assign is_lit_w = (st_q.instr[15:8] == `SFX_LIT_OPC);
  assign is_reg_w = (st_q.instr[15:10] == `SFX_REG_OPC);

  // effective data memory address, fixed at the end of decode
  always_comb begin
    if (fld_a_w) begin
      // bank select register supplies the upper bits
      eff_addr_w = {st_q.bank, fld_f_w};
    end else if (st_q.ext_en && (fld_f_w <= `SFX_ACC_LIMIT)) begin
      // indexed literal offset: base plus offset
      eff_addr_w = st_q.idx_base + {4'h0, fld_f_w};
    end else if (fld_f_w <= `SFX_ACC_LIMIT) begin
      // low half of the access bank
      eff_addr_w = {4'h0, fld_f_w};
    end else begin
      // high half of the access bank maps to the top page
      eff_addr_w = {`SFX_ACC_HI_BASE, fld_f_w};
    end
  end

  // ************************************************************
  // subtractor: minuend minus accumulator
  // ************************************************************
  // the register operand is taken straight off the memory bus in the process phase
  assign minuend_w = (st_q.op == SFX_OP_REG) ? mem_rdata : st_q.operand;
  assign brw_w[0]  = 1'b0;

  // two's complement difference, one borrow stage per bit
  for (genvar gi = 0; gi < 8; gi++) begin : g_sub
    assign diff_w[gi]    = minuend_w[gi] ^ st_q.accum[gi] ^ brw_w[gi];
    assign brw_w[gi + 1] = (!minuend_w[gi] && (st_q.accum[gi] || brw_w[gi]))
                           || (st_q.accum[gi] && brw_w[gi]);
  end

  // borrow out of the low nibble and out of the whole byte
  assign nib_borrow_w = brw_w[4];
  assign borrow_w     = brw_w[8];

  always_comb begin
    // carry and digit carry read as no borrow
    calc_flags_w                 = 5'h00;
    calc_flags_w[`SFX_ST_C_BIT]  = !borrow_w;
    calc_flags_w[`SFX_ST_DC_BIT] = !nib_borrow_w;
    calc_flags_w[`SFX_ST_Z_BIT]  = (diff_w == 8'h00);
    calc_flags_w[`SFX_ST_OV_BIT] = (minuend_w[7] != st_q.accum[7])
                                   && (diff_w[7] != minuend_w[7]);
    calc_flags_w[`SFX_ST_N_BIT]  = diff_w[7];
  end

  // ************************************************************
  // register read mux
  // ************************************************************
  always_comb begin
    rd_mux_w = 32'h0000_0000;
    mapped_w = 1'b1;
    case (paddr)
      `SFX_OFF_CTRL: begin
        rd_mux_w[`SFX_CTRL_EXT_BIT] = st_q.ext_en;
      end
      `SFX_OFF_INSTR: begin
        rd_mux_w[15:0] = st_q.instr;
      end
      `SFX_OFF_ACCUM: begin
        rd_mux_w[7:0] = st_q.accum;
      end
      `SFX_OFF_STATUS: begin
        rd_mux_w[4:0]              = st_q.flags;
        // bit 8 mirrors busy, bit 9 the outcome of the last decode
        rd_mux_w[`SFX_ST_BUSY_BIT] = busy_w;
        rd_mux_w[`SFX_ST_ILL_BIT]  = st_q.illegal;
      end
      `SFX_OFF_BANK: begin
        rd_mux_w[3:0] = st_q.bank;
      end
      `SFX_OFF_IDXBASE: begin
        rd_mux_w[11:0] = st_q.idx_base;
      end
      default: begin
        mapped_w = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_d        = st_q;
    new_instr_w = pwdata[15:0];

    // read data is latched in the setup cycle and stands through the access phase
    if (setup_w) begin
      st_d.prdata  = pwrite ? 32'h0000_0000 : rd_mux_w;
      st_d.pslverr = !mapped_w;
    end

    // software register writes
    if (wr_ok_w) begin
      case (paddr)
        `SFX_OFF_CTRL: begin
          st_d.ext_en = pwdata[`SFX_CTRL_EXT_BIT];
        end
        `SFX_OFF_ACCUM: begin
          st_d.accum = pwdata[7:0];
        end
        `SFX_OFF_STATUS: begin
          st_d.flags = pwdata[4:0];
        end
        `SFX_OFF_BANK: begin
          st_d.bank = pwdata[3:0];
        end
        `SFX_OFF_IDXBASE: begin
          st_d.idx_base = pwdata[11:0];
        end
        `SFX_OFF_INSTR: begin
          // an instruction write starts the four phase cycle
          st_d.instr = new_instr_w;
          st_d.phase = SFX_Q1;
        end
        default: begin
        end
      endcase
    end

    // four phase instruction cycle
    case (st_q.phase)
      SFX_IDLE: begin
      end
      SFX_Q1: begin
        st_d.phase   = SFX_Q2;
        st_d.illegal = 1'b0;
        if (is_lit_w) begin
          st_d.op = SFX_OP_LIT;
        end else if (is_reg_w) begin
          st_d.op       = SFX_OP_REG;
          st_d.mem_addr = eff_addr_w;
        end else begin
          // an unknown opcode changes no software register, it only raises illegal
          st_d.op      = SFX_OP_NONE;
          st_d.illegal = 1'b1;
        end
      end
      SFX_Q2: begin
        st_d.phase = SFX_Q3;
        if (st_q.op == SFX_OP_LIT) begin
          st_d.operand = fld_f_w;
        end
      end
      SFX_Q3: begin
        st_d.phase = SFX_Q4;
        // memory answers in the cycle after the read strobe
        if (st_q.op == SFX_OP_REG) begin
          st_d.operand = mem_rdata;
        end
      end
      SFX_Q4: begin
        st_d.phase = SFX_IDLE;
      end
      default: begin
        st_d.phase = SFX_IDLE;
      end
    endcase

    // process phase: the difference and its flags are held for the write phase
    if (in_q3_w) begin
      st_d.result    = diff_w;
      st_d.res_flags = calc_flags_w;
      st_d.mem_wdata = (st_q.op == SFX_OP_REG) ? diff_w : 8'h00;
    end

    // write phase: flags for any decoded subtract, accumulator unless the register takes the result
    if (in_q4_w && st_q.op != SFX_OP_NONE) begin
      st_d.flags = st_q.res_flags;
      if (st_q.op == SFX_OP_LIT || !fld_d_w) begin
        st_d.accum = st_q.result;
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // every field named so that none can slip past reset
      st_q.phase     <= SFX_IDLE;
      st_q.op        <= SFX_OP_NONE;
      st_q.instr     <= `SFX_RST_INSTR;
      st_q.accum     <= `SFX_RST_ACCUM;
      st_q.flags     <= `SFX_RST_FLAGS;
      st_q.illegal   <= 1'b0;
      st_q.ext_en    <= `SFX_RST_EXT;
      st_q.bank      <= `SFX_RST_BANK;
      st_q.idx_base  <= `SFX_RST_IDXBASE;
      st_q.operand   <= 8'h00;
      st_q.result    <= 8'h00;
      st_q.res_flags <= `SFX_RST_FLAGS;
      st_q.mem_addr  <= 12'h000;
      st_q.mem_wdata <= 8'h00;
      st_q.prdata    <= 32'h0000_0000;
      st_q.pslverr   <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // reads never wait; a write mid instruction would disturb its operands, so it stalls
  assign pready    = !(acc_w && pwrite && busy_w);
  // data outputs come straight from the state register
  assign prdata    = st_q.prdata;
  assign pslverr   = st_q.pslverr;
  assign mem_addr  = st_q.mem_addr;
  // read strobe in the operand phase of a register subtract
  assign mem_rd_en = in_q2_w && (st_q.op == SFX_OP_REG);
  // write back only for register destination
  assign mem_wr_en = in_q4_w && (st_q.op == SFX_OP_REG) && fld_d_w;
  assign mem_wdata = st_q.mem_wdata;
  assign busy      = busy_w;

endmodule : sfx_exec

// ### hdl/sfx_cfg.svh
// constants for the subtract execution block: offsets, fields, reset values, opcodes
//
// Behaviour
// - the literal subtract is the opcode whose upper byte is 0000 1000, its low byte an unsigned literal.
// - the literal subtract computes literal minus accumulator and writes the difference to the accumulator.
// - the literal subtract updates the negative, overflow, carry, digit carry and zero flags.
// - the register subtract is the opcode starting 0101 11 with d, a and an 8-bit address; it computes f minus accumulator.
// - with d clear the result goes to the accumulator, with d set it goes back to the register, accumulator unchanged.
// - with a clear and the extended set enabled, addresses up to 95 use indexed literal offset addressing.
`ifndef SFX_CFG_SVH
`define SFX_CFG_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define SFX_OFF_CTRL      12'h000
`define SFX_OFF_INSTR     12'h004
`define SFX_OFF_ACCUM     12'h008
`define SFX_OFF_STATUS    12'h00C
`define SFX_OFF_BANK      12'h010
`define SFX_OFF_IDXBASE   12'h014

// ************************************************************
// field positions
// ************************************************************
`define SFX_CTRL_EXT_BIT  0
`define SFX_ST_C_BIT      0
`define SFX_ST_DC_BIT     1
`define SFX_ST_Z_BIT      2
`define SFX_ST_OV_BIT     3
`define SFX_ST_N_BIT      4
`define SFX_ST_BUSY_BIT   8
`define SFX_ST_ILL_BIT    9
`define SFX_D_BIT         9
`define SFX_A_BIT         8

// ************************************************************
// opcodes and addressing
// ************************************************************
`define SFX_LIT_OPC       8'h08
`define SFX_REG_OPC       6'h17
`define SFX_ACC_LIMIT     8'h5F
`define SFX_ACC_HI_BASE   4'hF

// ************************************************************
// reset values
// ************************************************************
`define SFX_RST_INSTR     16'h0000
`define SFX_RST_ACCUM     8'h00
`define SFX_RST_FLAGS     5'h00
`define SFX_RST_BANK      4'h0
`define SFX_RST_IDXBASE   12'h000
`define SFX_RST_EXT       1'b0

`endif

// ### hdl/sfx_pkg.sv
// types for the subtract execution block
package sfx_pkg;

  // ************************************************************
  // instruction phase sequence, gray coded from SFX_IDLE to SFX_Q4; the return to SFX_IDLE flips two bits
  // ************************************************************
  typedef enum logic [2:0] {
    SFX_IDLE = 3'b000,
    SFX_Q1   = 3'b001,
    SFX_Q2   = 3'b011,
    SFX_Q3   = 3'b010,
    SFX_Q4   = 3'b110
  } sfx_phase_e;

  typedef enum logic [1:0] {
    SFX_OP_NONE = 2'h0,
    SFX_OP_LIT  = 2'h1,
    SFX_OP_REG  = 2'h2
  } sfx_op_e;

  // ************************************************************
  // complete block state
  // ************************************************************
  typedef struct packed {
    sfx_phase_e  phase;
    sfx_op_e     op;
    logic [15:0] instr;
    logic [7:0]  accum;
    logic [4:0]  flags;
    logic        illegal;
    logic        ext_en;
    logic [3:0]  bank;
    logic [11:0] idx_base;
    logic [7:0]  operand;
    logic [7:0]  result;
    logic [4:0]  res_flags;
    logic [11:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic [31:0] prdata;
    logic        pslverr;
  } sfx_state_s;

endpackage : sfx_pkg

// ### verification/sfx_mem_model.sv
// behavioural data memory facing the subtract block
`timescale 1ns/1ps
module sfx_mem_model (
  // memory port
  input  wire logic        pclk,
  input  wire logic [11:0] mem_addr,
  input  wire logic        mem_rd_en,
  output logic      [7:0]  mem_rdata,
  input  wire logic        mem_wr_en,
  input  wire logic [7:0]  mem_wdata
);
  logic [7:0] mem [4096];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
    mem_rdata = 8'h00;
  end
  // byte valid only in the cycle after the strobe, toggling otherwise
  always @(posedge pclk) begin
    mem_rdata <= mem_rd_en ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr_en) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule : sfx_mem_model

// ### verification/sfx_exec_chk.sv
// assertion checker for the subtract execution block
`timescale 1ns/1ps
`include "sfx_cfg.svh"
module sfx_exec_chk (
  // apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // memory and status
  input wire logic [11:0] mem_addr,
  input wire logic        mem_rd_en,
  input wire logic [7:0]  mem_rdata,
  input wire logic        mem_wr_en,
  input wire logic [7:0]  mem_wdata,
  input wire logic        busy
);
  wire logic tk = psel && penable && pready && pwrite && paddr == `SFX_OFF_INSTR;
  wire logic lit = tk && pwdata[15:8] == `SFX_LIT_OPC;
  wire logic rg = tk && pwdata[15:10] == `SFX_REG_OPC;
  wire logic [7:0] fa = pwdata[7:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_run; busy[*4] ##1 !busy; endsequence
  sequence s_rd; mem_rd_en ##1 !mem_rd_en; endsequence
  property p_run; lit || rg |=> s_run; endproperty
  a_run: assert property (p_run) else $error("busy span wrong");
  property p_rd; rg |-> ##2 s_rd; endproperty
  a_rd: assert property (p_rd) else $error("no operand read");
  property p_lit; lit |=> (!mem_rd_en && !mem_wr_en)[*5]; endproperty
  a_lit: assert property (p_lit) else $error("memory touched");
  property p_wr1; rg && pwdata[9] |-> ##4 mem_wr_en ##1 !mem_wr_en; endproperty
  a_wr1: assert property (p_wr1) else $error("no write back");
  property p_wr0; rg && !pwdata[9] |=> (!mem_wr_en)[*5]; endproperty
  a_wr0: assert property (p_wr0) else $error("stray write");
  property p_hi; rg && !pwdata[8] && fa > `SFX_ACC_LIMIT
    |-> ##2 mem_addr == {`SFX_ACC_HI_BASE, $past(fa, 2)}; endproperty
  a_hi: assert property (p_hi) else $error("address wrong");
  property p_wait; psel && penable && pwrite && busy |-> !pready; endproperty
  a_wait: assert property (p_wait) else $error("write not held");
  property p_same; mem_rd_en ##2 mem_wr_en |-> mem_addr == $past(mem_addr, 2); endproperty
  a_same: assert property (p_same) else $error("write address moved");
endmodule : sfx_exec_chk

// ### verification/tb.sv
// self-checking bench for the subtract execution block
`timescale 1ns/1ps
`include "sfx_cfg.svh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, sv;
  logic        mem_rd_en, mem_wr_en;
  logic [11:0] paddr, mem_addr, wa, a;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  mem_rdata, mem_wdata, wd, w, x;
  logic [3:0]  c;
  logic [15:0] op;
  int          mismatches, compares, cyc;
  logic [15:0] lt [5] = '{16'h0102, 16'h0202, 16'h0302, 16'h0180, 16'hFF00};
  logic [31:0] rt [6] = '{{4'h0, 16'h5C65, 12'hF65}, {4'h0, 16'h5E65, 12'hF65},
    {4'h0, 16'h5E10, 12'h010}, {4'h1, 16'h5E10, 12'h210},
    {4'h1, 16'h5F10, 12'h310}, {4'h1, 16'h5E60, 12'hF60}};
  sfx_exec i_sfx_exec (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .pready    (pready),
    .prdata    (prdata),
    .pslverr   (pslverr),
    .mem_addr  (mem_addr),
    .mem_rd_en (mem_rd_en),
    .mem_rdata (mem_rdata),
    .mem_wr_en (mem_wr_en),
    .mem_wdata (mem_wdata),
    .busy      (busy)
  );
  sfx_mem_model i_sfx_mem_model (
    .pclk      (pclk),
    .mem_addr  (mem_addr),
    .mem_rd_en (mem_rd_en),
    .mem_rdata (mem_rdata),
    .mem_wr_en (mem_wr_en),
    .mem_wdata (mem_wdata)
  );
  // ****
  // tasks
  // ****
  task chk(input string n, input logic [32:0] s, e);
    compares++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    sv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [4:0] flg(input logic [7:0] p, q);
    logic [7:0] d;
    d = p - q;
    return {d[7], (p[7] ^ q[7]) & (d[7] ^ p[7]), d == 8'h00, p[3:0] >= q[3:0], p >= q};
  endfunction : flg
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // ****
  // clock, write monitor, timeout
  // ****
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (mem_wr_en === 1'b1) begin
      wa <= mem_addr;
      wd <= mem_wdata;
    end
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  // ****
  // tests
  // ****
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk("reset", rd, 33'h0);
    end
    foreach (lt[i]) begin
      {w, x} = lt[i];
      apb(1'b1, `SFX_OFF_ACCUM, {24'h0, w});
      apb(1'b1, `SFX_OFF_INSTR, {16'h0, `SFX_LIT_OPC, x});
      apb(1'b0, `SFX_OFF_STATUS, 32'h0);
      chk("busy", rd[8], 33'h1);
      apb(1'b1, `SFX_OFF_BANK, 32'h3);
      apb(1'b0, `SFX_OFF_ACCUM, 32'h0);
      chk("accum", rd, {25'h0, 8'(x - w)});
      apb(1'b0, `SFX_OFF_STATUS, 32'h0);
      chk("flags", rd[4:0], flg(x, w));
    end
    apb(1'b1, `SFX_OFF_IDXBASE, 32'h200);
    foreach (rt[i]) begin
      {c, op, a} = rt[i];
      x = (a[7:0] ^ 8'h3C) - 8'h20;
      apb(1'b1, `SFX_OFF_CTRL, {28'h0, c});
      apb(1'b1, `SFX_OFF_ACCUM, 32'h20);
      apb(1'b1, `SFX_OFF_INSTR, {16'h0, op});
      apb(1'b1, `SFX_OFF_BANK, 32'h3);
      apb(1'b0, `SFX_OFF_ACCUM, 32'h0);
      chk("accum", rd, {25'h0, op[9] ? 8'h20 : x});
      apb(1'b0, `SFX_OFF_STATUS, 32'h0);
      chk("flags", rd[4:0], flg(a[7:0] ^ 8'h3C, 8'h20));
      chk("idle", rd[8], 33'h0);
      if (op[9]) begin
        chk("wr addr", wa, a);
        chk("wr data", wd, x);
      end
    end
    apb(1'b1, `SFX_OFF_INSTR, 32'hFFFF);
    repeat (6) @(posedge pclk);
    apb(1'b0, `SFX_OFF_STATUS, 32'h0);
    chk("illegal", rd[9], 33'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {sv, rd}, 33'h100000000);
    wrap_up();
  end
endmodule : tb
bind sfx_exec sfx_exec_chk i_sfx_exec_chk (
  .pclk      (pclk),
  .presetn   (presetn),
  .psel      (psel),
  .penable   (penable),
  .pwrite    (pwrite),
  .paddr     (paddr),
  .pwdata    (pwdata),
  .pready    (pready),
  .prdata    (prdata),
  .pslverr   (pslverr),
  .mem_addr  (mem_addr),
  .mem_rd_en (mem_rd_en),
  .mem_rdata (mem_rdata),
  .mem_wr_en (mem_wr_en),
  .mem_wdata (mem_wdata),
  .busy      (busy)
);
